/* File: pkg/ifmap_map.vh */
`ifndef IFMAP_MAP_VH
`define IFMAP_MAP_VH
// external data space offsets
`define IFMAP_ADDR_BYTE0 16'hf0e0
`define IFMAP_ADDR_BYTE1 16'hf0e1
`define IFMAP_ADDR_BYTE2 16'hf0e2
`define IFMAP_ADDR_BYTE3 16'hf0e3
`define IFMAP_ADDR_ACS_LOW 16'hf0e4
`define IFMAP_ADDR_ACS_HIGH 16'hf0e5
// high address / control field layout
`define IFMAP_HI_ADR_MSB 4
`define IFMAP_HI_ADR_LSB 8
`define IFMAP_HI_RESERVED_BIT 5
`define IFMAP_HI_BUSY_BIT 6
`define IFMAP_HI_DIR_BIT 7
// widths and reset values
`define IFMAP_ADR_W 13
`define IFMAP_WORD_W 32
`define IFMAP_BYTE_W 8
`define IFMAP_NUM_BYTES 4
`define IFMAP_LOW_MSB 7
`define IFMAP_DEPTH 8192
`define IFMAP_BYTE_RST 8'h00
`define IFMAP_ADR_RST 13'h0000
`define IFMAP_ADR_ONE 13'h0001
`define IFMAP_DIR_WRITE 1'b0
`define IFMAP_DIR_READ 1'b1
`endif

/* File: src/ifmap_mem.v */
`timescale 1ns/1ps
`include "ifmap_map.vh"
module ifmap_mem (
  input wire core_clk_i,
  input wire ce_i,
  input wire wr_en_i,
  input wire [`IFMAP_ADR_W-1:0] addr_i,
  input wire [`IFMAP_WORD_W-1:0] wr_data_i,
  output reg [`IFMAP_WORD_W-1:0] rd_data_o
);
  reg [`IFMAP_WORD_W-1:0] mem_array [0:`IFMAP_DEPTH-1];

  // single port buffer memory, registered read data
  always @(posedge core_clk_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem_array[addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_array[addr_i];
    end
  end
endmodule // ifmap_mem

/* File: src/ifmap_port.v */
// What this block does
// - Byte 3 of the exchanged word is a read/write register at F0E3 resetting to zero.
// - The low eight word address bits are a read/write register at F0E4.
// - F0E5 bits 4..0 hold address bits 12..8, reset zero, and bit 5 reads zero.
// - F0E5 bit 6 is a read-only busy flag set during a buffer fetch or store.
// - F0E5 bit 7 picks direction, 0 for writing the buffer and 1 for reading, reset 0.
// - Writing F0E5 with direction read fetches the addressed word into bytes 0..3 then bumps the address.
// - In write direction a write to byte 3 stores the assembled word and raises busy.
// - After a store busy drops and the address advances by one.
// - In read direction only a read of byte 3 starts the next prefetch.
// - Transfers continue from the advanced address until software writes a new address.
`timescale 1ns/1ps
`include "ifmap_map.vh"
module ifmap_port (
  input wire core_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [15:0] xaddr_i,
  input wire xwr_i,
  input wire xrd_i,
  input wire [7:0] xwdata_i,
  output reg [7:0] xrdata_o,
  output reg busy_o
);
  // sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_WRITE = 2'b01;
  localparam ST_FETCH = 2'b10;
  localparam ST_LOAD = 2'b11;

  // sequencer and register state
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`IFMAP_BYTE_W-1:0] byte_reg [0:`IFMAP_NUM_BYTES-1];
  reg [`IFMAP_ADR_W-1:0] buffer_word_address;
  reg access_direction;
  reg [`IFMAP_BYTE_W-1:0] rd_mux;

  // buffer memory side
  wire [`IFMAP_WORD_W-1:0] mem_rdata;
  wire [`IFMAP_WORD_W-1:0] word_out;
  wire mem_wr;

  // status and decode
  wire access_busy_flag;
  wire port_idle;
  wire hit_high;
  wire hit_low;
  wire hit_b3;
  wire wr_low_en;
  wire wr_high_en;
  wire wr_b3_en;
  wire rd_b3_en;
  wire start_fetch;
  wire start_store;
  wire start_prefetch;
  wire addr_step;
  wire [`IFMAP_BYTE_W-1:0] high_readback;

  // busy while any store, fetch or load is under way
  assign access_busy_flag = (state_reg != ST_IDLE);
  assign port_idle = (state_reg == ST_IDLE);

  // register address decode
  assign hit_high = (xaddr_i == `IFMAP_ADDR_ACS_HIGH);
  assign hit_low = (xaddr_i == `IFMAP_ADDR_ACS_LOW);
  assign hit_b3 = (xaddr_i == `IFMAP_ADDR_BYTE3);

  // accesses that count; writes while busy are dropped
  assign wr_low_en = xwr_i && hit_low && port_idle;
  assign wr_high_en = xwr_i && hit_high && port_idle;
  assign wr_b3_en = xwr_i && hit_b3 && port_idle;
  assign rd_b3_en = xrd_i && hit_b3 && port_idle;

  // the three ways a buffer access starts
  assign start_fetch = wr_high_en &&
                       (xwdata_i[`IFMAP_HI_DIR_BIT] == `IFMAP_DIR_READ);
  assign start_store = wr_b3_en && (access_direction == `IFMAP_DIR_WRITE);
  assign start_prefetch = rd_b3_en && (access_direction == `IFMAP_DIR_READ);

  // the address advances once per finished store or load
  assign addr_step = (state_reg == ST_WRITE) || (state_reg == ST_LOAD);
  assign mem_wr = (state_reg == ST_WRITE);

  // high register readback: direction, busy, reserved zero, address top
  assign high_readback = {access_direction, access_busy_flag, 1'b0,
                          buffer_word_address[`IFMAP_ADR_W-1:`IFMAP_HI_ADR_LSB]};

  // buffer memory, one word per address
  ifmap_mem u_mem (
    .core_clk_i(core_clk_i),
    .ce_i(ce_i),
    .wr_en_i(mem_wr),
    .addr_i(buffer_word_address),
    .wr_data_i(word_out),
    .rd_data_o(mem_rdata)
  );

  // sequencer: store, or fetch then load bytes
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_fetch) begin
          state_next = ST_FETCH;
        end else if (start_store) begin
          state_next = ST_WRITE;
        end else if (start_prefetch) begin
          state_next = ST_FETCH;
        end
      end
      ST_WRITE: begin
        state_next = ST_IDLE;
      end
      ST_FETCH: begin
        state_next = ST_LOAD;
      end
      ST_LOAD: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer state register
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // word address; a software write restarts the sequence
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      buffer_word_address <= `IFMAP_ADR_RST;
    end else if (ce_i) begin
      if (wr_low_en) begin
        buffer_word_address[`IFMAP_LOW_MSB:0] <= xwdata_i;
      end else if (wr_high_en) begin
        buffer_word_address[`IFMAP_ADR_W-1:`IFMAP_HI_ADR_LSB] <=
          xwdata_i[`IFMAP_HI_ADR_MSB:0];
      end else if (addr_step) begin
        buffer_word_address <= buffer_word_address + `IFMAP_ADR_ONE;
      end
    end
  end

  // direction bit, taken with every accepted high register write
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      access_direction <= `IFMAP_DIR_WRITE;
    end else if (ce_i) begin
      if (wr_high_en) begin
        access_direction <= xwdata_i[`IFMAP_HI_DIR_BIT];
      end
    end
  end

  // data byte registers, loaded by software or by a fetch
  genvar gi;
  generate
    for (gi = 0; gi < `IFMAP_NUM_BYTES; gi = gi + 1) begin : g_byte
      // external data space address of this byte register
      localparam integer BYTE_ADDR = `IFMAP_ADDR_BYTE0 + gi;
      wire wr_en;
      // software write, taken only while the port is idle
      assign wr_en = xwr_i && port_idle && (xaddr_i == BYTE_ADDR[15:0]);
      // byte 0 is the least significant byte of the word
      assign word_out[gi*`IFMAP_BYTE_W +: `IFMAP_BYTE_W] = byte_reg[gi];
      always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          byte_reg[gi] <= `IFMAP_BYTE_RST;
        end else if (ce_i) begin
          if (state_reg == ST_LOAD) begin
            byte_reg[gi] <= mem_rdata[gi*`IFMAP_BYTE_W +: `IFMAP_BYTE_W];
          end else if (wr_en) begin
            byte_reg[gi] <= xwdata_i;
          end
        end
      end
    end
  endgenerate

  // read data select; unmapped addresses read zero
  always @* begin
    rd_mux = `IFMAP_BYTE_RST;
    case (xaddr_i)
      `IFMAP_ADDR_BYTE0: begin
        rd_mux = byte_reg[0];
      end
      `IFMAP_ADDR_BYTE1: begin
        rd_mux = byte_reg[1];
      end
      `IFMAP_ADDR_BYTE2: begin
        rd_mux = byte_reg[2];
      end
      `IFMAP_ADDR_BYTE3: begin
        rd_mux = byte_reg[3];
      end
      `IFMAP_ADDR_ACS_LOW: begin
        rd_mux = buffer_word_address[`IFMAP_LOW_MSB:0];
      end
      `IFMAP_ADDR_ACS_HIGH: begin
        rd_mux = high_readback;
      end
      default: begin
        rd_mux = `IFMAP_BYTE_RST;
      end
    endcase
  end

  // read data register, loaded only on the edge that takes a read
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      xrdata_o <= `IFMAP_BYTE_RST;
    end else if (ce_i) begin
      if (xrd_i) begin
        xrdata_o <= rd_mux;
      end
    end
  end

  // busy output follows the busy flag from the same edge on
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= (state_next != ST_IDLE);
    end
  end
endmodule // ifmap_port

/* File: testbench/ifmap_mcu.sv */
`timescale 1ns/1ps
module ifmap_mcu (
  input logic core_clk_i,
  input logic [7:0] xrdata_i,
  output logic [15:0] xaddr_o,
  output logic xwr_o,
  output logic xrd_o,
  output logic [7:0] xwdata_o
);
  initial {xaddr_o, xwr_o, xrd_o, xwdata_o} = 26'h0;
  // one access: strobe for one edge, data inverted once released
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge core_clk_i);
    xaddr_o = a;
    xwdata_o = d;
    xwr_o = w;
    xrd_o = !w;
    @(negedge core_clk_i);
    xwr_o = 1'h0;
    xrd_o = 1'h0;
    xwdata_o = ~d;
    q = xrdata_i;
  endtask
endmodule // ifmap_mcu

/* File: testbench/ifmap_port_chk.sv */
`timescale 1ns/1ps
module ifmap_port_chk (
  input logic core_clk_i,
  input logic reset_i,
  input logic ce_i,
  input logic [15:0] xaddr_i,
  input logic xwr_i,
  input logic xrd_i,
  input logic [7:0] xwdata_i,
  input logic [7:0] xrdata_o,
  input logic busy_o
);
  logic dir_q;
  // decoded strobes, triggers only count while idle
  wire wr5 = ce_i && xwr_i && xaddr_i == 16'hf0e5 && !busy_o;
  wire wr3 = ce_i && xwr_i && xaddr_i == 16'hf0e3 && !busy_o;
  wire rd3 = ce_i && xrd_i && xaddr_i == 16'hf0e3 && !busy_o;
  wire rd5 = ce_i && xrd_i && xaddr_i == 16'hf0e5 && !busy_o;
  // direction as last written
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i) dir_q <= 1'h0;
    else if (wr5) dir_q <= xwdata_i[7];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_reserved_reads_zero: assert property (rd5 |=> !xrdata_o[5]) else $error("reserved set");
  a_dir_readback: assert property (rd5 |=> xrdata_o[7] == dir_q) else $error("dir");
  a_busy_ends: assert property (busy_o |-> ##[1:3] !busy_o) else $error("busy");
  a_fetch_start: assert property (wr5 && xwdata_i[7] |-> ##[1:2] busy_o) else $error("f");
  a_store_start: assert property (wr3 && !dir_q |-> ##[1:2] busy_o) else $error("st");
  a_prefetch_go: assert property (rd3 && dir_q |-> ##[1:2] busy_o) else $error("pf");
  a_rdata_hold: assert property (!(ce_i && xrd_i) |=> $stable(xrdata_o)) else $error("rd");
  a_ce_freeze: assert property (!ce_i |=> $stable(busy_o)) else $error("ce");
  c_store: cover property (wr3 && !dir_q);
  c_fetch: cover property (wr5 && xwdata_i[7]);
  c_prefetch: cover property (rd3 && dir_q);
endmodule // ifmap_port_chk
bind ifmap_port ifmap_port_chk chk (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i),
  .xaddr_i(xaddr_i), .xwr_i(xwr_i), .xrd_i(xrd_i), .xwdata_i(xwdata_i),
  .xrdata_o(xrdata_o), .busy_o(busy_o));

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic core_clk_i = 0, reset_i = 1, ce_i = 1, xwr_i, xrd_i, busy_o;
  logic [15:0] xaddr_i;
  logic [7:0] xwdata_i, xrdata_o, q;
  logic [31:0] mem[int];
  int failures = 0, checks = 0, a, n;
  always #4 core_clk_i = ~core_clk_i;
  ifmap_port dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .xaddr_i(xaddr_i),
    .xwr_i(xwr_i), .xrd_i(xrd_i), .xwdata_i(xwdata_i), .xrdata_o(xrdata_o), .busy_o(busy_o));
  ifmap_mcu mcu (.core_clk_i(core_clk_i), .xrdata_i(xrdata_o), .xaddr_o(xaddr_i),
    .xwr_o(xwr_i), .xrd_o(xrd_i), .xwdata_o(xwdata_i));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // bounded poll until the port is idle again
  task automatic idle;
    n = 0;
    repeat (3) @(negedge core_clk_i);
    while (busy_o !== 1'h0) begin
      n++;
      if (n > 8) failures++;
      if (n > 8) finish_test();
      @(negedge core_clk_i);
    end
  endtask
  task automatic setadr(input logic d);
    mcu.acc(1'h1, 16'hf0e4, 8'(a), q);
    mcu.acc(1'h1, 16'hf0e5, {d, 2'h0, 5'(a >> 8)}, q);
    idle();
  endtask
  initial begin
    void'($urandom(30239));
    repeat (2) @(negedge core_clk_i);
    reset_i = 0;
    mcu.acc(1'h0, 16'hf0e3, 8'h00, q);
    cmp(q, 8'h00);
    mcu.acc(1'h0, 16'hf0e5, 8'h00, q);
    cmp(q, 8'h00);
    ce_i = 0;
    mcu.acc(1'h1, 16'hf0e3, 8'ha5, q);
    ce_i = 1;
    mcu.acc(1'h0, 16'hf0e3, 8'h00, q);
    cmp(q, 8'h00);
    a = $urandom % 8000;
    setadr(1'h0);
    for (int i = 0; i < 4; i++) begin
      mem[a + i] = $urandom;
      for (int b = 0; b < 4; b++) mcu.acc(1'h1, 16'hf0e0 | 16'(b), 8'(mem[a + i] >> 8 * b), q);
      cmp({7'h0, busy_o}, 8'h01);
      idle();
    end
    mcu.acc(1'h0, 16'hf0e4, 8'h00, q);
    cmp(q, 8'(a + 4));
    setadr(1'h1);
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 4; b++) begin
        mcu.acc(1'h0, 16'hf0e0 | 16'(b), 8'h00, q);
        cmp(q, 8'(mem[a + i] >> 8 * b));
      end
      cmp({7'h0, busy_o}, 8'h01);
      idle();
    end
    mcu.acc(1'h0, 16'hf0e5, 8'h00, q);
    cmp(q, {3'h4, 5'((a + 5) >> 8)});
    finish_test();
  end
endmodule // tb
